// ---- flow_control_unit.sv ----
// Purpose: program-flow execution of a 16-bit core: branches, loops, jumps, calls
// Assumes: AHB-Lite register port, byte-wide memory port on the same clock
// Notes: PC holds the address after the instruction; software writes OPND, then CMD
//
// Functional notes
// - true long branch adds signed 16-bit displacement to program counter
// - long displacement -32768..+32767 from address after the displacement
// - unconditional long branch always taken; never form is a no-operation
// - simple long branches test one flag: C, Z, N or V
// - higher: C|Z=0; higher-or-same: C=0; lower-or-same: C|Z=1
// - signed: N^V=0 ge, =1 lt; Z|(N^V)=0 gt, =1 le
// - bit branch: byte AND mask; set form all ones, clear form all zeros
// - bit branch displacement is signed 8-bit, -128..+127
// - loop counter is A, B, D, X, Y or SP; branch on zero/non-zero
// - decrement forms subtract one, write back, then test new value
// - increment forms add one, write back, then test new value
// - test forms leave counter unchanged and test it
// - loop displacement is signed 9-bit, -256..+255
// - jump loads PC from absolute or indexed effective address
// - subroutine call: SP-2, return high at SP, low at SP+1, jump
// - return: PC from SP and SP+1, then SP+2
// - page call pushes return, SP-1, stores page, loads new page, jumps
// - page from immediate, or from memory in indirect mode with address
// - page return: page from SP, SP+1, PC from SP/SP+1, SP+2
// - page call and return work without expanded addressing hardware
//
// Implementation choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`include "cfu_defines.svh"

module flow_control_unit (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // byte memory port
  output logic memReq,
  output logic memWe,
  output logic [15:0] memAddr,
  output logic [7:0] memWdata,
  input wire logic memAck,
  input wire logic [7:0] memRdata
);
  import cfu_pkg::*;

  state_s s_q;
  state_s s_d;
  logic startW;
  op_e startOp;
  logic [15:0] cv;
  logic [15:0] nv;
  logic lpHit;

  // ****************************************
  // condition evaluation
  // ****************************************
  function automatic logic longCond(input op_e op, input logic [3:0] f);
    logic c, v, z, n;
    c = f[`CFU_CCR_C];
    v = f[`CFU_CCR_V];
    z = f[`CFU_CCR_Z];
    n = f[`CFU_CCR_N];
    case (op)
      OP_LONG_ALWAYS: longCond = 1'b1;
      OP_LONG_CCLR: longCond = !c;
      OP_LONG_CSET: longCond = c;
      OP_LONG_EQ: longCond = z;
      OP_LONG_MI: longCond = n;
      OP_LONG_NE: longCond = !z;
      OP_LONG_PL: longCond = !n;
      OP_LONG_VCLR: longCond = !v;
      OP_LONG_VSET: longCond = v;
      OP_LONG_HI: longCond = !(c | z);
      OP_LONG_HS: longCond = !c;
      OP_LONG_LO: longCond = c;
      OP_LONG_LS: longCond = c | z;
      OP_LONG_GE: longCond = !(n ^ v);
      OP_LONG_GT: longCond = !(z | (n ^ v));
      OP_LONG_LE: longCond = z | (n ^ v);
      OP_LONG_LT: longCond = n ^ v;
      default: longCond = 1'b0;
    endcase
  endfunction : longCond

  function automatic logic [31:0] regRead(input state_s s, input logic [7:0] a);
    case (a)
      `CFU_OFF_CMD: regRead = {27'h0000000, s.op};
      `CFU_OFF_OPND: regRead = s.opnd;
      `CFU_OFF_PC: regRead = {16'h0000, s.pc};
      `CFU_OFF_SP: regRead = {16'h0000, s.sp};
      `CFU_OFF_CCR: regRead = {28'h0000000, s.ccr};
      `CFU_OFF_D: regRead = {16'h0000, s.d};
      `CFU_OFF_X: regRead = {16'h0000, s.x};
      `CFU_OFF_Y: regRead = {16'h0000, s.y};
      `CFU_OFF_PAGE: regRead = {24'h000000, s.page};
      `CFU_OFF_STAT: regRead = {30'h00000000, s.taken, s.st != ST_IDLE};
      default: regRead = 32'h00000000;
    endcase
  endfunction : regRead

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s_q.hrdata;
  assign memReq = s_q.st != ST_IDLE;
  assign memWe = s_q.memWe;
  assign memAddr = s_q.memAddr;
  assign memWdata = s_q.memWdata;

  // commands are refused while a memory sequence is running
  assign startW = s_q.bSel && s_q.bWr && s_q.bAdr == `CFU_OFF_CMD && s_q.st == ST_IDLE;
  assign startOp = op_e'(hwdata[4:0]);

  // ****************************************
  // loop counter arithmetic
  // ****************************************
  always_comb begin
    case (cnt_e'(hwdata[7:5]))
      CNT_A: cv = {8'h00, s_q.d[15:8]};
      CNT_B: cv = {8'h00, s_q.d[7:0]};
      CNT_D: cv = s_q.d;
      CNT_X: cv = s_q.x;
      CNT_Y: cv = s_q.y;
      CNT_SP: cv = s_q.sp;
      default: cv = 16'h0000;
    endcase
    case (startOp)
      OP_DECZ, OP_DECNZ: nv = cv - 16'h0001;
      OP_INCZ, OP_INCNZ: nv = cv + 16'h0001;
      default: nv = cv;
    endcase
    // 8-bit accumulators wrap inside their own byte
    if (hwdata[7:6] == 2'b00 && hwdata[5] == 1'b0 || hwdata[7:5] == 3'b001) begin
      nv[15:8] = 8'h00;
    end
    if (startOp == OP_DECZ || startOp == OP_INCZ || startOp == OP_TSTZ) begin
      lpHit = nv == 16'h0000;
    end else begin
      lpHit = nv != 16'h0000;
    end
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_d = s_q;
    s_d.bSel = hsel && htrans[1] && hready;
    s_d.bWr = hwrite;
    s_d.bAdr = haddr[7:0];
    if (hsel && htrans[1] && hready && !hwrite) begin
      s_d.hrdata = regRead(s_q, haddr[7:0]);
    end
    if (s_q.bSel && s_q.bWr && s_q.st == ST_IDLE) begin
      case (s_q.bAdr)
        `CFU_OFF_OPND: s_d.opnd = hwdata;
        `CFU_OFF_PC: s_d.pc = hwdata[15:0];
        `CFU_OFF_SP: s_d.sp = hwdata[15:0];
        `CFU_OFF_CCR: s_d.ccr = hwdata[3:0];
        `CFU_OFF_D: s_d.d = hwdata[15:0];
        `CFU_OFF_X: s_d.x = hwdata[15:0];
        `CFU_OFF_Y: s_d.y = hwdata[15:0];
        `CFU_OFF_PAGE: s_d.page = hwdata[7:0];
        default: ;
      endcase
    end
    if (startW) begin
      s_d.op = startOp;
      s_d.taken = 1'b0;
      case (startOp)
        OP_BITSET, OP_BITCLR: begin
          s_d.ptr = s_q.opnd[15:0];
          s_d.st = ST_BIT;
        end
        OP_DECZ, OP_DECNZ, OP_INCZ, OP_INCNZ, OP_TSTZ, OP_TSTNZ: begin
          if (hwdata[7:5] <= 3'b101) begin
            case (cnt_e'(hwdata[7:5]))
              CNT_A: s_d.d[15:8] = nv[7:0];
              CNT_B: s_d.d[7:0] = nv[7:0];
              CNT_D: s_d.d = nv;
              CNT_X: s_d.x = nv;
              CNT_Y: s_d.y = nv;
              default: s_d.sp = nv;
            endcase
            if (lpHit) begin
              s_d.taken = 1'b1;
              s_d.pc = s_q.pc + {{7{s_q.opnd[8]}}, s_q.opnd[8:0]};
            end
          end
        end
        OP_JUMP: begin
          s_d.pc = s_q.opnd[15:0];
          s_d.taken = 1'b1;
        end
        OP_RELSUB, OP_JMPSUB: begin
          s_d.tgt = startOp == OP_RELSUB ? s_q.pc + {{8{s_q.opnd[7]}}, s_q.opnd[7:0]}
            : s_q.opnd[15:0];
          s_d.sp = s_q.sp - 16'h0002;
          s_d.st = ST_PUSH_HI;
        end
        OP_CALLPG: begin
          if (hwdata[`CFU_CMD_IND]) begin
            s_d.ptr = s_q.opnd[15:0];
            s_d.st = ST_RD_HI;
          end else begin
            s_d.tgt = s_q.opnd[15:0];
            s_d.newPage = s_q.opnd[23:16];
            s_d.sp = s_q.sp - 16'h0002;
            s_d.st = ST_PUSH_HI;
          end
        end
        OP_RETPG: s_d.st = ST_POP_PG;
        OP_RETSUB: s_d.st = ST_POP_HI;
        default: begin
          if (longCond(startOp, s_q.ccr)) begin
            s_d.taken = 1'b1;
            s_d.pc = s_q.pc + s_q.opnd[15:0];
          end
        end
      endcase
    end else if (s_q.st != ST_IDLE && memAck) begin
      unique case (s_q.st)
        ST_RD_HI: begin
          s_d.tgt[15:8] = memRdata;
          s_d.st = ST_RD_LO;
        end
        ST_RD_LO: begin
          s_d.tgt[7:0] = memRdata;
          s_d.st = ST_RD_PG;
        end
        ST_RD_PG: begin
          s_d.newPage = memRdata;
          s_d.sp = s_q.sp - 16'h0002;
          s_d.st = ST_PUSH_HI;
        end
        ST_PUSH_HI: s_d.st = ST_PUSH_LO;
        ST_PUSH_LO: begin
          if (s_q.op == OP_CALLPG) begin
            s_d.sp = s_q.sp - 16'h0001;
            s_d.st = ST_PUSH_PG;
          end else begin
            s_d.pc = s_q.tgt;
            s_d.taken = 1'b1;
            s_d.st = ST_IDLE;
          end
        end
        ST_PUSH_PG: begin
          // the page register always exists, so a flat system simply sees it unused
          s_d.page = s_q.newPage;
          s_d.pc = s_q.tgt;
          s_d.taken = 1'b1;
          s_d.st = ST_IDLE;
        end
        ST_POP_PG: begin
          s_d.page = memRdata;
          s_d.sp = s_q.sp + 16'h0001;
          s_d.st = ST_POP_HI;
        end
        ST_POP_HI: begin
          s_d.tgt[15:8] = memRdata;
          s_d.st = ST_POP_LO;
        end
        ST_POP_LO: begin
          s_d.pc = {s_q.tgt[15:8], memRdata};
          s_d.sp = s_q.sp + 16'h0002;
          s_d.taken = 1'b1;
          s_d.st = ST_IDLE;
        end
        ST_BIT: begin
          s_d.taken = ((s_q.op == OP_BITSET ? ~memRdata : memRdata) & s_q.opnd[23:16])
            == 8'h00;
          if (s_d.taken) begin
            s_d.pc = s_q.pc + {{8{s_q.opnd[31]}}, s_q.opnd[31:24]};
          end
          s_d.st = ST_IDLE;
        end
        default: s_d.st = ST_IDLE;
      endcase
    end
    // memory request follows the step just chosen
    s_d.memWe = 1'b0;
    s_d.memWdata = 8'h00;
    case (s_d.st)
      ST_RD_HI, ST_BIT: s_d.memAddr = s_d.ptr;
      ST_RD_LO: s_d.memAddr = s_d.ptr + 16'h0001;
      ST_RD_PG: s_d.memAddr = s_d.ptr + 16'h0002;
      ST_PUSH_HI: begin
        s_d.memAddr = s_d.sp;
        s_d.memWe = 1'b1;
        s_d.memWdata = s_d.pc[15:8];
      end
      ST_PUSH_LO: begin
        s_d.memAddr = s_d.sp + 16'h0001;
        s_d.memWe = 1'b1;
        s_d.memWdata = s_d.pc[7:0];
      end
      ST_PUSH_PG: begin
        s_d.memAddr = s_d.sp;
        s_d.memWe = 1'b1;
        s_d.memWdata = s_d.page;
      end
      ST_POP_LO: s_d.memAddr = s_d.sp + 16'h0001;
      ST_POP_HI, ST_POP_PG: s_d.memAddr = s_d.sp;
      default: s_d.memAddr = s_q.memAddr;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      s_q <= '0;
      s_q.pc <= `CFU_RST_PC;
      s_q.sp <= `CFU_RST_SP;
      s_q.page <= `CFU_RST_PAGE;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  property p_long_always;
    startW && startOp == OP_LONG_ALWAYS |=> s_q.pc == $past(s_q.pc) + $past(s_q.opnd[15:0]);
  endproperty
  a_long_always: assert property (p_long_always) else $error("always branch missed");

  property p_long_never;
    startW && startOp == OP_LONG_NEVER |=> s_q.pc == $past(s_q.pc) && !s_q.taken;
  endproperty
  a_long_never: assert property (p_long_never) else $error("never branch moved pc");

  property p_long_eq;
    startW && startOp == OP_LONG_EQ |=> s_q.taken == $past(s_q.ccr[`CFU_CCR_Z]);
  endproperty
  a_long_eq: assert property (p_long_eq) else $error("equal branch wrong");

  property p_long_hi;
    startW && startOp == OP_LONG_HI
      |=> s_q.taken == !($past(s_q.ccr[`CFU_CCR_C]) | $past(s_q.ccr[`CFU_CCR_Z]));
  endproperty
  a_long_hi: assert property (p_long_hi) else $error("higher branch wrong");

  property p_long_lo;
    startW && startOp == OP_LONG_LO |=> s_q.taken == $past(s_q.ccr[`CFU_CCR_C]);
  endproperty
  a_long_lo: assert property (p_long_lo) else $error("lower branch wrong");

  property p_long_gt;
    startW && startOp == OP_LONG_GT |=> s_q.taken == !($past(s_q.ccr[`CFU_CCR_Z])
      | ($past(s_q.ccr[`CFU_CCR_N]) ^ $past(s_q.ccr[`CFU_CCR_V])));
  endproperty
  a_long_gt: assert property (p_long_gt) else $error("greater branch wrong");

  property p_bitclr;
    s_q.st == ST_BIT && memAck && s_q.op == OP_BITCLR
      |=> s_q.taken == (($past(memRdata) & $past(s_q.opnd[23:16])) == 8'h00);
  endproperty
  a_bitclr: assert property (p_bitclr) else $error("bit clear test wrong");

  property p_decx;
    startW && startOp == OP_DECNZ && hwdata[7:5] == CNT_X
      |=> s_q.x == $past(s_q.x) - 16'h0001 && s_q.taken == (s_q.x != 16'h0000);
  endproperty
  a_decx: assert property (p_decx) else $error("decrement loop wrong");

  property p_call_push;
    startW && startOp == OP_JMPSUB
      |=> s_q.sp == $past(s_q.sp) - 16'h0002 && memReq && memWe && memAddr == s_q.sp;
  endproperty
  a_call_push: assert property (p_call_push) else $error("call push wrong");

  property p_rts;
    s_q.st == ST_POP_LO && memAck
      |=> s_q.pc[7:0] == $past(memRdata) && s_q.st == ST_IDLE && s_q.taken;
  endproperty
  a_rts: assert property (p_rts) else $error("return pc wrong");

  c_loop: cover property (startW && startOp == OP_DECNZ ##1 s_q.taken);
  c_call: cover property (s_q.st == ST_PUSH_PG && memAck);
  c_ret: cover property (s_q.st == ST_POP_PG ##[1:20] s_q.st == ST_IDLE);
  c_bit: cover property (s_q.st == ST_BIT && memAck && s_q.op == OP_BITSET);

endmodule : flow_control_unit

// ---- cfu_defines.svh ----
// Purpose: register offsets, field positions and reset values of the flow control unit
// Assumes: 32-bit AHB-Lite register port, one aligned word per register
// Notes: definitions only
`ifndef CFU_DEFINES_SVH
`define CFU_DEFINES_SVH

// ****************************************
// register byte offsets
// ****************************************
`define CFU_OFF_CMD 8'h00
`define CFU_OFF_OPND 8'h04
`define CFU_OFF_PC 8'h08
`define CFU_OFF_SP 8'h0c
`define CFU_OFF_CCR 8'h10
`define CFU_OFF_D 8'h14
`define CFU_OFF_X 8'h18
`define CFU_OFF_Y 8'h1c
`define CFU_OFF_PAGE 8'h20
`define CFU_OFF_STAT 8'h24

// ****************************************
// field positions
// ****************************************
`define CFU_CCR_C 0
`define CFU_CCR_V 1
`define CFU_CCR_Z 2
`define CFU_CCR_N 3
`define CFU_CMD_IND 8

// ****************************************
// reset values
// ****************************************
`define CFU_RST_PC 16'h0000
`define CFU_RST_SP 16'h0000
`define CFU_RST_PAGE 8'h00

`endif

// ---- cfu_pkg.sv ----
// Purpose: types shared by the flow control unit
// Assumes: cfu_defines.svh carries the numbers
// Notes: opcode space is exactly 32 codes, so no code is illegal
package cfu_pkg;

  typedef enum logic [4:0] {
    OP_LONG_ALWAYS = 5'h00, OP_LONG_NEVER = 5'h01, OP_LONG_CCLR = 5'h02, OP_LONG_CSET = 5'h03,
    OP_LONG_EQ = 5'h04, OP_LONG_MI = 5'h05, OP_LONG_NE = 5'h06, OP_LONG_PL = 5'h07,
    OP_LONG_VCLR = 5'h08, OP_LONG_VSET = 5'h09, OP_LONG_HI = 5'h0a, OP_LONG_HS = 5'h0b,
    OP_LONG_LO = 5'h0c, OP_LONG_LS = 5'h0d, OP_LONG_GE = 5'h0e, OP_LONG_GT = 5'h0f,
    OP_LONG_LE = 5'h10, OP_LONG_LT = 5'h11, OP_BITSET = 5'h12, OP_BITCLR = 5'h13,
    OP_DECZ = 5'h14, OP_DECNZ = 5'h15, OP_INCZ = 5'h16, OP_INCNZ = 5'h17,
    OP_TSTZ = 5'h18, OP_TSTNZ = 5'h19, OP_JUMP = 5'h1a, OP_RELSUB = 5'h1b,
    OP_JMPSUB = 5'h1c, OP_CALLPG = 5'h1d, OP_RETPG = 5'h1e, OP_RETSUB = 5'h1f
  } op_e;

  typedef enum logic [2:0] {
    CNT_A = 3'b000, CNT_B = 3'b001, CNT_D = 3'b010,
    CNT_X = 3'b011, CNT_Y = 3'b100, CNT_SP = 3'b101
  } cnt_e;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000, ST_RD_HI = 4'b0001, ST_RD_LO = 4'b0010,
    ST_RD_PG = 4'b0011, ST_PUSH_HI = 4'b0100, ST_PUSH_LO = 4'b0101,
    ST_PUSH_PG = 4'b0110, ST_POP_HI = 4'b0111, ST_POP_LO = 4'b1000,
    ST_POP_PG = 4'b1001, ST_BIT = 4'b1010
  } step_e;

  typedef struct packed {
    step_e st;
    op_e op;
    logic [15:0] pc;
    logic [15:0] sp;
    logic [15:0] d;
    logic [15:0] x;
    logic [15:0] y;
    logic [3:0] ccr;
    logic [7:0] page;
    logic [31:0] opnd;
    logic [15:0] ptr;
    logic [15:0] tgt;
    logic [7:0] newPage;
    logic taken;
    logic [15:0] memAddr;
    logic memWe;
    logic [7:0] memWdata;
    logic bSel;
    logic bWr;
    logic [7:0] bAdr;
    logic [31:0] hrdata;
  } state_s;

endpackage : cfu_pkg

// ---- mem_model.sv ----
// Purpose: byte memory holding program code and stack for the flow control unit
// Assumes: same clock as the unit, one access at a time, high byte at lower address
// Notes: waitCyc sets the idle cycles before each acknowledge, so slow memory is tried too
`timescale 1ns/10ps

module mem_model (
  // clock
  input wire logic clk_sys,
  // access port
  input wire logic memReq,
  input wire logic memWe,
  input wire logic [15:0] memAddr,
  input wire logic [7:0] memWdata,
  output logic memAck,
  output logic [7:0] memRdata,
  // pacing
  input wire logic [3:0] waitCyc
);
  logic [7:0] mem [0:65535];
  logic [3:0] cnt;

  // ****************************************
  // access engine
  // ****************************************
  initial begin
    memAck = 1'b0;
    memRdata = 8'h00;
    cnt = 4'h0;
  end

  always @(posedge clk_sys) begin
    memAck <= 1'b0;
    // read data only means something with the acknowledge, so it is scrambled otherwise
    memRdata <= ~memRdata;
    if (memReq && !memAck) begin
      if (cnt == waitCyc) begin
        cnt <= 4'h0;
        memAck <= 1'b1;
        if (memWe) begin
          mem[memAddr] <= memWdata;
        end else begin
          memRdata <= mem[memAddr];
        end
      end else begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule : mem_model

// ---- cpu_flow_control_unit_tb.sv ----
// Purpose: self-checking bench of the flow control unit over its register port
// Assumes: zero-wait slave, memory model on the byte port
// Notes: expected values are worked out here from flag, counter and stack arithmetic
`timescale 1ns/10ps
`include "cfu_defines.svh"

module cpu_flow_control_unit_tb;
  import cfu_pkg::*;
  logic clk_sys, reset_n, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic memReq, memWe, memAck;
  logic [15:0] memAddr;
  logic [7:0] memWdata, memRdata;
  logic [3:0] waitCyc;
  int n_fail = 0;
  int compares = 0;

  assign hready = hreadyout;

  flow_control_unit u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .memReq(memReq), .memWe(memWe),
    .memAddr(memAddr), .memWdata(memWdata), .memAck(memAck), .memRdata(memRdata));

  mem_model u_mem (.clk_sys(clk_sys), .memReq(memReq), .memWe(memWe), .memAddr(memAddr),
    .memWdata(memWdata), .memAck(memAck), .memRdata(memRdata), .waitCyc(waitCyc));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic waitReady();
    int i;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_sys);
      if (hready === 1'b1) break;
    end
    if (i == 20) begin
      n_fail++;
      summarize();
    end
  endtask : waitReady

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    waitReady();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    waitReady();
    rd = hrdata;
  endtask : bus

  task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    bus(1'b1, a, d, dummy);
  endtask : regWrite

  task automatic regRead(input logic [7:0] a, output logic [31:0] d);
    bus(1'b0, a, 32'h0, d);
  endtask : regRead

  // memory instructions stay busy a while; the poll is bounded
  task automatic exec(input logic [31:0] cmd, input logic [31:0] opnd);
    logic [31:0] s;
    int i;
    regWrite(`CFU_OFF_OPND, opnd);
    regWrite(`CFU_OFF_CMD, cmd);
    for (i = 0; i < 60; i++) begin
      regRead(`CFU_OFF_STAT, s);
      if (s[0] === 1'b0) break;
    end
    if (i == 60) begin
      n_fail++;
      summarize();
    end
  endtask : exec

  task automatic expReg(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    regRead(a, r);
    check("register", r, e);
  endtask : expReg

  function automatic logic lbTake(input logic [4:0] op, input logic [3:0] f);
    logic c, v, z, n;
    c = f[`CFU_CCR_C];
    v = f[`CFU_CCR_V];
    z = f[`CFU_CCR_Z];
    n = f[`CFU_CCR_N];
    case (op)
      5'h00: return 1'b1;
      5'h01: return 1'b0;
      5'h02, 5'h0b: return !c;
      5'h03, 5'h0c: return c;
      5'h04: return z;
      5'h05: return n;
      5'h06: return !z;
      5'h07: return !n;
      5'h08: return !v;
      5'h09: return v;
      5'h0a: return !(c | z);
      5'h0d: return c | z;
      5'h0e: return !(n ^ v);
      5'h0f: return !(z | (n ^ v));
      5'h10: return z | (n ^ v);
      default: return n ^ v;
    endcase
  endfunction : lbTake

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    logic [31:0] r;
    logic [15:0] disp, cv, nv, wv, ex;
    logic [15:0] bm [4];
    logic [7:0] ad;
    logic t;
    int f, o, s, k, w;
    bm = '{16'hf0f0, 16'h1030, 16'h0ff0, 16'h0000};
    reset_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    waitCyc = 4'h0;
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    expReg(`CFU_OFF_PC, 32'h0);
    expReg(`CFU_OFF_SP, 32'h0);
    expReg(`CFU_OFF_PAGE, 32'h0);
    check("resp", {31'h0, hresp}, 32'h0);
    // every long branch under every flag combination, +32767 on even codes and -32768 on odd ones
    for (f = 0; f < 16; f++) begin
      regWrite(`CFU_OFF_CCR, 32'(f));
      for (o = 0; o < 18; o++) begin
        disp = o[0] ? 16'h8000 : 16'h7fff;
        t = lbTake(o[4:0], f[3:0]);
        regWrite(`CFU_OFF_PC, 32'h8000);
        regWrite(`CFU_OFF_OPND, {16'h0, disp});
        regWrite(`CFU_OFF_CMD, 32'(o));
        regRead(`CFU_OFF_PC, r);
        check("long pc", r, t ? {16'h0, 16'h8000 + disp} : 32'h8000);
        regRead(`CFU_OFF_STAT, r);
        check("long taken", r, {30'h0, t, 1'b0});
      end
    end
    // loop primitives on every counter, boundary value then an ordinary one
    for (s = 0; s < 6; s++) begin
      ad = s < 3 ? `CFU_OFF_D : (s == 3 ? `CFU_OFF_X : (s == 4 ? `CFU_OFF_Y : `CFU_OFF_SP));
      for (o = 20; o < 26; o++) begin
        for (k = 0; k < 2; k++) begin
          cv = k ? 16'h0005 : (o < 22 ? 16'h0001 : (o < 24 ? 16'hffff : 16'h0000));
          nv = o < 22 ? cv - 16'h1 : (o < 24 ? cv + 16'h1 : cv);
          t = (s < 2 ? nv[7:0] == 8'h00 : nv == 16'h0) ^ o[0];
          wv = s == 0 ? {cv[7:0], 8'h5a} : (s == 1 ? {8'ha5, cv[7:0]} : cv);
          ex = s == 0 ? {nv[7:0], 8'h5a} : (s == 1 ? {8'ha5, nv[7:0]} : nv);
          regWrite(ad, {16'h0, wv});
          regWrite(`CFU_OFF_PC, 32'h0200);
          regWrite(`CFU_OFF_OPND, k ? 32'h0ff : 32'h100);
          regWrite(`CFU_OFF_CMD, {24'h0, s[2:0], o[4:0]});
          regRead(`CFU_OFF_PC, r);
          check("loop pc", r, t ? (k ? 32'h02ff : 32'h0100) : 32'h0200);
          regRead(ad, r);
          check("loop counter", r, {16'h0, ex});
        end
      end
    end
    regWrite(`CFU_OFF_PC, 32'h0200);
    regWrite(`CFU_OFF_CMD, 32'hd5);
    expReg(`CFU_OFF_PC, 32'h0200);
    expReg(`CFU_OFF_STAT, 32'h0);
    regWrite(`CFU_OFF_OPND, 32'hbeef);
    regWrite(`CFU_OFF_CMD, 32'h1a);
    expReg(`CFU_OFF_PC, 32'hbeef);
    // bit branches over a mask table, both forms
    for (k = 0; k < 4; k++) begin
      for (o = 18; o < 20; o++) begin
        u_mem.mem[16'h0500] = bm[k][15:8];
        t = o[0] ? (bm[k][15:8] & bm[k][7:0]) == 8'h0 : (~bm[k][15:8] & bm[k][7:0]) == 8'h0;
        regWrite(`CFU_OFF_PC, 32'h0400);
        exec(32'(o), {k[0] ? 8'h80 : 8'h7f, bm[k][7:0], 16'h0500});
        expReg(`CFU_OFF_PC, t ? (k[0] ? 32'h0380 : 32'h047f) : 32'h0400);
      end
    end
    // calls and returns with prompt and with slow memory
    for (w = 0; w < 2; w++) begin
      waitCyc <= w ? 4'h3 : 4'h0;
      u_mem.mem[16'h00fe] = 8'h00;
      u_mem.mem[16'h00ff] = 8'h00;
      regWrite(`CFU_OFF_SP, 32'h0100);
      regWrite(`CFU_OFF_PC, 32'h1234);
      exec(32'h1c, 32'h4000);
      expReg(`CFU_OFF_PC, 32'h4000);
      expReg(`CFU_OFF_SP, 32'h00fe);
      check("stack hi", u_mem.mem[16'h00fe], 8'h12);
      check("stack lo", u_mem.mem[16'h00ff], 8'h34);
      exec(32'h1f, 32'h0);
      expReg(`CFU_OFF_PC, 32'h1234);
      expReg(`CFU_OFF_SP, 32'h0100);
      exec(32'h1b, 32'h0080);
      expReg(`CFU_OFF_PC, 32'h11b4);
      regWrite(`CFU_OFF_SP, 32'h0100);
      regWrite(`CFU_OFF_PC, 32'h1234);
      regWrite(`CFU_OFF_PAGE, 32'h07);
      u_mem.mem[16'h00fd] = 8'h00;
      exec(32'h1d, 32'h003c8000);
      check("stack page", u_mem.mem[16'h00fd], 8'h07);
      expReg(`CFU_OFF_SP, 32'h00fd);
      expReg(`CFU_OFF_PAGE, 32'h3c);
      expReg(`CFU_OFF_PC, 32'h8000);
      exec(32'h1e, 32'h0);
      expReg(`CFU_OFF_PAGE, 32'h07);
      expReg(`CFU_OFF_PC, 32'h1234);
      expReg(`CFU_OFF_SP, 32'h0100);
      u_mem.mem[16'h0300] = 8'h9a;
      u_mem.mem[16'h0301] = 8'hbc;
      u_mem.mem[16'h0302] = 8'h55;
      exec(32'h11d, 32'h0300);
      expReg(`CFU_OFF_PC, 32'h9abc);
      expReg(`CFU_OFF_PAGE, 32'h55);
      check("stack page", u_mem.mem[16'h00fd], 8'h07);
      exec(32'h1e, 32'h0);
    end
    // a write during a slow return must not disturb it
    waitCyc <= 4'hf;
    u_mem.mem[16'h0100] = 8'h21;
    u_mem.mem[16'h0101] = 8'h43;
    regWrite(`CFU_OFF_SP, 32'h0100);
    regWrite(`CFU_OFF_CMD, 32'h1f);
    regWrite(`CFU_OFF_PC, 32'hffff);
    exec(32'h1a, 32'h0);
    expReg(`CFU_OFF_SP, 32'h0102);
    expReg(`CFU_OFF_PC, 32'h2143);
    regWrite(8'h28, 32'hffffffff);
    expReg(8'h28, 32'h0);
    summarize();
  end
endmodule : cpu_flow_control_unit_tb
